// *** common/irs_pkg.sv ***
// Package with constants for the interrupt request and sleep entry block.
package irs_pkg;
	localparam int unsigned IRS_NSRC_DEF = 8;
	localparam int unsigned IRS_LVL_W = 3;
	localparam int unsigned IRS_ADDR_W = 8;
	// Byte addresses of the registers on the Wishbone slave.
	localparam logic [7:0] IRS_OFF_PEND = 8'h00;
	localparam logic [7:0] IRS_OFF_ENA = 8'h04;
	localparam logic [7:0] IRS_OFF_CTRL = 8'h08;
	localparam logic [7:0] IRS_OFF_SP = 8'h0C;
	localparam logic [7:0] IRS_OFF_ACK = 8'h10;
	localparam logic [7:0] IRS_OFF_CFG = 8'h14;
	localparam logic [7:0] IRS_OFF_IST = 8'h18;
	localparam logic [7:0] IRS_OFF_IMSK = 8'h1C;
	// Control register bit positions.
	localparam int unsigned IRS_CTRL_FLASH = 0;
	localparam int unsigned IRS_CTRL_STOP = 1;
	localparam int unsigned IRS_CTRL_WAIT = 2;
	// Interrupt status bit positions.
	localparam int unsigned IRS_IST_REQ = 0;
	localparam int unsigned IRS_IST_STOP = 1;
	localparam int unsigned IRS_IST_WAKE = 2;
	localparam int unsigned IRS_IST_SPBAD = 3;
	localparam int unsigned IRS_IST_W = 4;
	// Reset values.
	localparam logic [15:0] IRS_SP_RST = 16'h0000;
	localparam logic [19:0] IRS_VEC_ADDR = 20'h00000;
	// Bytes the instruction queue must hold before the core halts.
	localparam int unsigned IRS_PREFETCH_BYTES = 4;
	// Bytes after a RAM write that a wait exit may restore.
	localparam int unsigned IRS_RAM_GUARD_BYTES = 3;
	typedef enum logic [1:0] {
		IRS_RUN,
		IRS_FETCH,
		IRS_HALT
	} irs_mode_t;
endpackage : irs_pkg

// *** design/irs_prio.sv ***
// Priority picker: lowest-indexed source with the highest non-zero level wins.
`timescale 1ns/1ns
module irs_prio
	import irs_pkg::*;
#(
	parameter int unsigned NSRC = IRS_NSRC_DEF
) (
	// Candidates
	input  wire logic [NSRC-1:0]           cand_i,
	input  wire logic [NSRC*IRS_LVL_W-1:0] lvl_i,
	// Winner
	output logic                           any_o,
	output logic [NSRC-1:0]                win_o,
	output logic [IRS_LVL_W-1:0]           win_lvl_o
);
	always_comb begin
		any_o = 1'b0;
		win_o = '0;
		win_lvl_o = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (cand_i[i] && lvl_i[i*IRS_LVL_W +: IRS_LVL_W] != '0 &&
			    (!any_o ||
			     lvl_i[i*IRS_LVL_W +: IRS_LVL_W] > win_lvl_o)) begin
				any_o = 1'b1;
				win_o = '0;
				win_o[i] = 1'b1;
				win_lvl_o = lvl_i[i*IRS_LVL_W +: IRS_LVL_W];
			end
		end
	end
endmodule : irs_prio

// *** design/irs_top.sv ***
// Interrupt request flags, acknowledge fetch and stop/wait entry.
`timescale 1ns/1ns
module irs_top
	import irs_pkg::*;
#(
	parameter int unsigned NSRC = IRS_NSRC_DEF
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Wishbone slave
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [IRS_ADDR_W-1:0]     wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic [31:0]                    wb_dat_o,
	output logic                           wb_ack_o,
	// Peripheral request events, one-cycle pulses
	input  wire logic [NSRC-1:0]           src_event_i,
	// Source selection changes, one-cycle pulses
	input  wire logic [NSRC-1:0]           src_reconf_i,
	// Core acknowledge interface
	output logic                           core_irq_o,
	input  wire logic                      core_ack_i,
	output logic                           vec_valid_o,
	output logic [19:0]                    vec_addr_o,
	output logic [7:0]                     vec_num_o,
	output logic [IRS_LVL_W-1:0]           vec_lvl_o,
	// Core sleep interface
	input  wire logic [3:0]                queue_bytes_i,
	input  wire logic                      wake_i,
	output logic                           core_halt_o,
	output logic                           stop_mode_select,
	output logic                           flash_self_rewrite_enable,
	output logic [15:0]                    stack_pointer_reg,
	// RAM write tracking for wait exit
	input  wire logic                      ram_wr_i,
	input  wire logic [15:0]               ram_adr_i,
	input  wire logic [7:0]                ram_dat_i,
	input  wire logic                      other_acc_i,
	output logic                           ram_fix_we_o,
	output logic [15:0]                    ram_fix_adr_o,
	output logic [7:0]                     ram_fix_dat_o,
	// Interrupt output
	output logic                           irq_o
);
	// Every level field must fit in one 32-bit configuration word.
	if (NSRC < 1 || NSRC * IRS_LVL_W > 32) begin : g_bad_nsrc
		$error("irs_top: NSRC must be 1 to 10");
	end

	logic [NSRC-1:0]           request_pending_flag;
	logic [NSRC-1:0]           ena_reg;
	logic [NSRC*IRS_LVL_W-1:0] lvl_reg;
	logic [IRS_IST_W-1:0]      ist_reg;
	logic [IRS_IST_W-1:0]      imsk_reg;
	logic                      wait_req_reg;
	logic                      ack_reg;
	irs_mode_t                 mode_reg;
	logic                      any;
	logic [NSRC-1:0]           win;
	logic [IRS_LVL_W-1:0]      win_lvl;
	logic [7:0]                win_num;
	logic                      wr;
	logic                      rd;
	logic                      ack_take;
	logic                      vec_rd;
	logic [NSRC-1:0]           flag_clr;
	logic                      ram_dirty_reg;
	logic [15:0]               ram_last_adr_reg;
	logic [7:0]                ram_last_dat_reg;
	logic [1:0]                fix_cnt_reg;
	logic                      sleep_go;
	logic [IRS_IST_W-1:0]      ist_evt;

	irs_prio #(
		.NSRC (NSRC)
	) u_prio (
		.cand_i    (request_pending_flag & ena_reg),
		.lvl_i     (lvl_reg),
		.any_o     (any),
		.win_o     (win),
		.win_lvl_o (win_lvl)
	);

	always_comb begin
		win_num = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (win[i]) begin
				win_num = 8'(i);
			end
		end
	end

	// Writes land at the edge at which the master sees ack; reads are
	// latched one edge earlier so that their data stands with ack.
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	assign ack_take = core_ack_i && any && mode_reg == IRS_FETCH;
	assign vec_rd = rd && wb_adr_i == IRS_OFF_ACK && any;

	// Apart from acknowledges, only a full plain write of the pending word clears flags.
	assign flag_clr = (wr && wb_adr_i == IRS_OFF_PEND && wb_sel_i == 4'hF)
		? ~wb_dat_i[NSRC-1:0] : '0;

	// Set wins over every clear; control writes never touch the flags.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			request_pending_flag <= '0;
		end else begin
			request_pending_flag <= (request_pending_flag & ~flag_clr
				& ~((ack_take || vec_rd) ? win : '0))
				| src_event_i | src_reconf_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ena_reg <= '0;
			lvl_reg <= '0;
		end else begin
			if (wr && wb_adr_i == IRS_OFF_ENA && wb_sel_i[0]) begin
				ena_reg <= wb_dat_i[NSRC-1:0];
			end
			if (wr && wb_adr_i == IRS_OFF_CFG) begin
				lvl_reg <= wb_dat_i[NSRC*IRS_LVL_W-1:0];
			end
		end
	end

	// Reset leaves the pointer at zero; core acknowledges are refused until
	// software has loaded something else.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_pointer_reg <= IRS_SP_RST;
		end else if (wr && wb_adr_i == IRS_OFF_SP) begin
			stack_pointer_reg <= wb_dat_i[15:0];
		end
	end

	assign sleep_go = wr && wb_adr_i == IRS_OFF_CTRL;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_self_rewrite_enable <= 1'b0;
			stop_mode_select <= 1'b0;
			wait_req_reg <= 1'b0;
		end else begin
			if (sleep_go) begin
				flash_self_rewrite_enable <= wb_dat_i[IRS_CTRL_FLASH];
				stop_mode_select <= wb_dat_i[IRS_CTRL_STOP];
				wait_req_reg <= wb_dat_i[IRS_CTRL_WAIT];
			end else if (mode_reg == IRS_HALT && wake_i) begin
				stop_mode_select <= 1'b0;
				wait_req_reg <= 1'b0;
			end
		end
	end

	// Halt waits for the queue to hold the following bytes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= IRS_RUN;
		end else begin
			unique case (mode_reg)
				IRS_RUN: begin
					if ((stop_mode_select || wait_req_reg) &&
					    queue_bytes_i >= 4'(IRS_PREFETCH_BYTES)) begin
						mode_reg <= IRS_HALT;
					end else if (any && stack_pointer_reg != IRS_SP_RST) begin
						mode_reg <= IRS_FETCH;
					end
				end
				IRS_FETCH: begin
					if (ack_take || !any) begin
						mode_reg <= IRS_RUN;
					end
				end
				IRS_HALT: begin
					if (wake_i) begin
						mode_reg <= IRS_RUN;
					end
				end
			endcase
		end
	end

	assign core_halt_o = mode_reg == IRS_HALT;
	assign core_irq_o = mode_reg == IRS_FETCH;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_valid_o <= 1'b0;
			vec_addr_o <= IRS_VEC_ADDR;
			vec_num_o <= '0;
			vec_lvl_o <= '0;
		end else begin
			vec_valid_o <= ack_take;
			if (ack_take) begin
				vec_addr_o <= IRS_VEC_ADDR;
				vec_num_o <= win_num;
				vec_lvl_o <= win_lvl;
			end
		end
	end

	// Track the last RAM write; a jump or other access breaks the hazard.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_dirty_reg <= 1'b0;
			ram_last_adr_reg <= '0;
			ram_last_dat_reg <= '0;
		end else if (ram_wr_i) begin
			ram_dirty_reg <= 1'b1;
			ram_last_adr_reg <= ram_adr_i;
			ram_last_dat_reg <= ram_dat_i;
		end else if (other_acc_i || (mode_reg == IRS_HALT && wake_i)) begin
			ram_dirty_reg <= 1'b0;
		end
	end

	// Exiting wait right after a RAM write replays the value into the
	// next three bytes, as the real queue does; a model of that hazard.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fix_cnt_reg <= '0;
		end else if (mode_reg == IRS_HALT && wake_i && wait_req_reg &&
		             !stop_mode_select && ram_dirty_reg) begin
			fix_cnt_reg <= 2'(IRS_RAM_GUARD_BYTES);
		end else if (fix_cnt_reg != '0) begin
			fix_cnt_reg <= fix_cnt_reg - 2'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_fix_we_o <= 1'b0;
			ram_fix_adr_o <= '0;
			ram_fix_dat_o <= '0;
		end else begin
			ram_fix_we_o <= fix_cnt_reg != '0;
			ram_fix_adr_o <= ram_last_adr_reg + 16'(4'(IRS_RAM_GUARD_BYTES)
				- 4'(fix_cnt_reg) + 4'd1);
			ram_fix_dat_o <= ram_last_dat_reg;
		end
	end

	assign ist_evt[IRS_IST_REQ] = ack_take;
	assign ist_evt[IRS_IST_STOP] = mode_reg == IRS_RUN &&
		(stop_mode_select || wait_req_reg) &&
		queue_bytes_i >= 4'(IRS_PREFETCH_BYTES);
	assign ist_evt[IRS_IST_WAKE] = mode_reg == IRS_HALT && wake_i;
	assign ist_evt[IRS_IST_SPBAD] = mode_reg == IRS_RUN && any &&
		stack_pointer_reg == IRS_SP_RST;

	// Write one to clear; a new event in the same cycle survives.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_reg <= '0;
			imsk_reg <= '0;
		end else begin
			ist_reg <= (ist_reg & ~((wr && wb_adr_i == IRS_OFF_IST)
				? wb_dat_i[IRS_IST_W-1:0] : '0)) | ist_evt;
			if (wr && wb_adr_i == IRS_OFF_IMSK) begin
				imsk_reg <= wb_dat_i[IRS_IST_W-1:0];
			end
		end
	end

	assign irq_o = |(ist_reg & imsk_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			ack_reg <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= '0;
			if (rd) begin
				unique case (wb_adr_i)
					IRS_OFF_PEND: wb_dat_o <= 32'(request_pending_flag);
					IRS_OFF_ENA:  wb_dat_o <= 32'(ena_reg);
					IRS_OFF_CTRL: wb_dat_o <= {29'h0, wait_req_reg,
						stop_mode_select, flash_self_rewrite_enable};
					IRS_OFF_SP:   wb_dat_o <= {16'h0, stack_pointer_reg};
					IRS_OFF_ACK:  wb_dat_o <= {20'h0, 1'(any), win_lvl, win_num};
					IRS_OFF_CFG:  wb_dat_o <= 32'(lvl_reg);
					IRS_OFF_IST:  wb_dat_o <= 32'(ist_reg);
					IRS_OFF_IMSK: wb_dat_o <= 32'(imsk_reg);
					default:      wb_dat_o <= '0;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_reg;
endmodule : irs_top

// *** dv/irs_top_asserts.sv ***
// Concurrent checks on the ports of the interrupt and sleep block.
`timescale 1ns/1ns
module irs_top_asserts
	import irs_pkg::*;
(
	// Clock and reset
	input wire logic	clk_i,
	input wire logic	rst_i,
	// Watched ports
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_ack_o,
	input wire logic	core_irq_o,
	input wire logic	core_ack_i,
	input wire logic	vec_valid_o,
	input wire logic [19:0]	vec_addr_o,
	input wire logic [3:0]	queue_bytes_i,
	input wire logic	wake_i,
	input wire logic	core_halt_o,
	input wire logic [15:0]	stack_pointer_reg,
	input wire logic	ram_fix_we_o,
	input wire logic [15:0]	ram_fix_adr_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_burst;
		ram_fix_we_o [*3] ##1 !ram_fix_we_o;
	endsequence
	a_bus_answer: assert property (s_take |=> wb_ack_o)
		else $error("bus ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
	a_vec_follows: assert property (core_irq_o && core_ack_i |=> vec_valid_o)
		else $error("vector not delivered");
	a_vec_addr: assert property (vec_valid_o |-> vec_addr_o == IRS_VEC_ADDR)
		else $error("vector address wrong");
	a_sp_gate: assert property ($rose(core_irq_o) |-> $past(stack_pointer_reg) != 16'h0000)
		else $error("fetch with zero stack pointer");
	a_halt_queue: assert property ($rose(core_halt_o) |-> $past(queue_bytes_i) >= IRS_PREFETCH_BYTES)
		else $error("halt before queue filled");
	a_halt_exit: assert property ($fell(core_halt_o) |-> $past(wake_i) || $past(wake_i, 2))
		else $error("halt left without wake");
	a_fix_burst: assert property ($rose(ram_fix_we_o) |-> s_burst)
		else $error("replay is not three writes");
	a_fix_step: assert property (ram_fix_we_o && $past(ram_fix_we_o) |-> ram_fix_adr_o == $past(ram_fix_adr_o) + 16'h0001)
		else $error("replay address not stepping");
endmodule : irs_top_asserts

bind irs_top irs_top_asserts u_asserts (.*);

// *** dv/irs_core_model.sv ***
// Behavioural processor core facing the block.
`timescale 1ns/1ns
module irs_core_model (
	// Clock and reset
	input wire logic	clk_i,
	input wire logic	rst_i,
	// Bench controls
	input wire logic	ack_en_i,
	input wire logic [3:0]	lag_i,
	// Block side
	input wire logic	core_irq_o,
	input wire logic	wake_i,
	output logic		core_ack_i,
	output logic [3:0]	queue_bytes_i
);
	logic [3:0] wait_reg;
	// A fresh count after each acknowledge avoids taking one request twice.
	always_ff @(posedge clk_i) begin
		core_ack_i <= 1'h0;
		if (rst_i || !core_irq_o || core_ack_i)
			wait_reg <= 4'h0;
		else if (wait_reg >= lag_i && ack_en_i)
			core_ack_i <= 1'h1;
		else
			wait_reg <= wait_reg + 4'h1;
	end
	// A wake restarts fetching, so the queue refills one byte a cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i || wake_i)
			queue_bytes_i <= 4'h0;
		else if (queue_bytes_i != 4'h8)
			queue_bytes_i <= queue_bytes_i + 4'h1;
	end
endmodule : irs_core_model

// *** dv/irs_top_tb.sv ***
// Self-checking bench for the interrupt request and sleep block.
`timescale 1ns/1ns
module irs_top_tb
	import irs_pkg::*;
;
	logic	clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic	wake_i = 0, ram_wr_i = 0, other_acc_i = 0, ack_en = 0;
	logic	wb_ack_o, core_irq_o, core_ack_i, vec_valid_o, core_halt_o;
	logic	stop_mode_select, flash_self_rewrite_enable, ram_fix_we_o, irq_o;
	logic [3:0]	wb_sel_i = 0, queue_bytes_i, lag = 1;
	logic [7:0]	wb_adr_i = 0, src_event_i = 0, src_reconf_i = 0, ram_dat_i = 0;
	logic [7:0]	vec_num_o, ram_fix_dat_o;
	logic [15:0]	ram_adr_i = 0, stack_pointer_reg, ram_fix_adr_o;
	logic [19:0]	vec_addr_o;
	logic [2:0]	vec_lvl_o;
	logic [31:0]	wb_dat_i = 0, wb_dat_o, rd;
	int	fails = 0, total_checks = 0;

	always #10 clk_i = ~clk_i;
	irs_top dut (.*);
	irs_core_model u_core (.ack_en_i(ack_en), .lag_i(lag), .*);

	task automatic tally_and_finish;
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge clk_i);
		if (n == 50) begin
			fails++;
			tally_and_finish;
		end
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d, 4'hF);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		wb(1'h0, a, 32'h0, 4'hF);
	endtask : rdr

	task automatic pulse_ev(input logic [7:0] v);
		src_event_i <= v;
		@(posedge clk_i);
		src_event_i <= 8'h00;
	endtask : pulse_ev

	task automatic wvec(input logic [7:0] num, input logic [2:0] lvl);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (vec_valid_o !== 1'h1 && n < 50);
		chk(vec_valid_o, 1'h1);
		chk(vec_num_o, num);
		chk(vec_lvl_o, lvl);
		chk(vec_addr_o, 20'h00000);
	endtask : wvec

	task automatic t_sp_block;
		chk(stack_pointer_reg, 16'h0000);
		wr(IRS_OFF_CFG, 32'h000284D1);
		wr(IRS_OFF_ENA, 32'h000000FF);
		ack_en <= 1'h1;
		pulse_ev(8'h01);
		repeat (6) @(posedge clk_i);
		chk(core_irq_o, 1'h0);
		chk(irq_o, 1'h0);
		wr(IRS_OFF_IMSK, 32'h0000000F);
		chk(irq_o, 1'h1);
		wr(IRS_OFF_SP, 32'h00000400);
		chk(stack_pointer_reg, 16'h0400);
		wvec(8'h00, 3'h1);
		repeat (3) @(posedge clk_i);
		wr(IRS_OFF_IST, 32'h0000000F);
		chk(irq_o, 1'h0);
	endtask : t_sp_block

	task automatic t_prio;
		lag <= 4'h4;
		pulse_ev(8'h24);
		wvec(8'h05, 3'h5);
		wvec(8'h02, 3'h3);
		repeat (3) @(posedge clk_i);
		rdr(IRS_OFF_PEND);
		chk(rd[7:0], 8'h00);
		rdr(IRS_OFF_IST);
		chk(rd[0], 1'h1);
		wr(IRS_OFF_IST, 32'h0000000F);
	endtask : t_prio

	task automatic t_prog_read;
		ack_en <= 1'h0;
		pulse_ev(8'h0A);
		repeat (8) @(posedge clk_i);
		rdr(IRS_OFF_PEND);
		chk(rd[7:0], 8'h0A);
		rdr(IRS_OFF_ACK);
		chk(rd[11:0], 12'hA01);
		rdr(IRS_OFF_PEND);
		chk(rd[7:0], 8'h08);
		wr(IRS_OFF_PEND, 32'h0);
	endtask : t_prog_read

	task automatic t_reflag;
		src_reconf_i <= 8'h40;
		@(posedge clk_i);
		src_reconf_i <= 8'h00;
		rdr(IRS_OFF_PEND);
		chk(rd[7:0], 8'h40);
		wb(1'h1, IRS_OFF_PEND, 32'h0, 4'h1);
		rdr(IRS_OFF_PEND);
		chk(rd[7:0], 8'h40);
		wr(IRS_OFF_PEND, 32'h0);
		fork
			wr(IRS_OFF_CFG, 32'h000284D1);
			begin
				@(posedge clk_i);
				pulse_ev(8'h40);
			end
		join
		rdr(IRS_OFF_PEND);
		chk(rd[7:0], 8'h40);
		wr(IRS_OFF_PEND, 32'h0);
		rdr(8'h40);
		chk(rd, 32'h0);
		wr(IRS_OFF_CTRL, 32'h1);
		chk(flash_self_rewrite_enable, 1'h1);
		ack_en <= 1'h1;
	endtask : t_reflag

	task automatic t_sleep(input logic [31:0] ctrl, input logic oth,
		input int nfix);
		int k;
		wake_i <= 1'h1;
		@(posedge clk_i);
		wake_i <= 1'h0;
		ram_wr_i <= 1'h1;
		ram_adr_i <= 16'h0601;
		ram_dat_i <= 8'h55;
		@(posedge clk_i);
		ram_wr_i <= 1'h0;
		other_acc_i <= oth;
		@(posedge clk_i);
		other_acc_i <= 1'h0;
		wr(IRS_OFF_CTRL, ctrl);
		chk(stop_mode_select, ctrl[1]);
		k = 0;
		while (core_halt_o !== 1'h1 && k < 30) begin
			@(posedge clk_i);
			k++;
		end
		chk(core_halt_o, 1'h1);
		wake_i <= 1'h1;
		@(posedge clk_i);
		wake_i <= 1'h0;
		k = 0;
		repeat (12) begin
			@(posedge clk_i);
			if (ram_fix_we_o === 1'h1) begin
				chk(ram_fix_adr_o, 32'h602 + k);
				chk(ram_fix_dat_o, 8'h55);
				k++;
			end
		end
		chk(k, nfix);
		chk(core_halt_o, 1'h0);
		rdr(IRS_OFF_IST);
		chk(rd[2:1], 2'h3);
		wr(IRS_OFF_IST, 32'h0000000F);
	endtask : t_sleep

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		t_sp_block;
		t_prio;
		t_prog_read;
		t_reflag;
		t_sleep(32'h4, 1'h0, 3);
		t_sleep(32'h4, 1'h1, 0);
		t_sleep(32'h2, 1'h0, 0);
		tally_and_finish;
	end

	initial begin
		#60000;
		fails++;
		tally_and_finish;
	end
endmodule : irs_top_tb
